// [hw/omcc_pkg.sv]
// Package with constants and types of the operating mode clock controller
package omcc_pkg;

   // Register offsets on the plain register port
   localparam logic [3:0] OMCC_CTRL_ADDR = 4'h0;
   localparam logic [3:0] OMCC_OSC_ADDR = 4'h1;
   localparam logic [3:0] OMCC_STAT_ADDR = 4'h2;
   localparam logic [3:0] OMCC_WDOG_ADDR = 4'h3;

   // Field positions
   localparam int OMCC_SEL_LSB = 5;
   localparam int OMCC_FIDLE_BIT = 1;
   localparam int OMCC_SIDLE_BIT = 0;
   localparam int OMCC_FEN_BIT = 0;
   localparam int OMCC_FSTB_BIT = 1;
   localparam int OMCC_WDEXP_BIT = 5;
   localparam int OMCC_PWRDN_BIT = 4;

   // Reset values
   localparam logic [2:0] OMCC_SEL_RST = 3'h0;
   localparam logic OMCC_FAST_EN_RST = 1'b1;
   localparam logic OMCC_WDT_EN_RST = 1'b1;

   // Select code of the slow clock
   localparam logic [2:0] OMCC_SEL_SLOW = 3'h7;

   // Oscillator settle time in ns and in mclk cycles (least time, round up)
   localparam int OMCC_CLK_NS = 5;
   localparam int OMCC_SETTLE_NS = 1000;
   localparam int OMCC_SETTLE_CYC =
      (OMCC_SETTLE_NS + OMCC_CLK_NS - 1) / OMCC_CLK_NS;

   // Operating modes, one-hot
   typedef enum logic [5:0] {
      OMCC_NORMAL = 6'h01,
      OMCC_SLOW = 6'h02,
      OMCC_SLEEP = 6'h04,
      OMCC_IDLE_SLOW = 6'h08,
      OMCC_IDLE_BOTH = 6'h10,
      OMCC_IDLE_FAST = 6'h20
   } omcc_mode_t;

   // Clock gate outputs towards CPU and peripherals
   typedef struct packed {
      logic core_en;
      logic fast_en;
      logic slow_en;
      logic slow_raw_en;
   } omcc_gates_t;

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } omcc_bus_t;

endpackage : omcc_pkg

// [hw/omcc_clk_div.sv]
// Divider of the fast clock with glitch free selection of the core clock
`timescale 1ns/1ps
`default_nettype none
module omcc_clk_div import omcc_pkg::*; #(
   parameter int STAGES = 6
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic fast_tick,
   input wire logic slow_tick,
   input wire logic [2:0] sel,
   input wire logic run,
   output logic core_tick
);

   // Select codes reach ratio 64 (index 6), so fewer stages cannot serve them
   if (STAGES < 6 || STAGES > 7) begin : g_bad_stages
      $error("omcc_clk_div: STAGES out of range");
   end

   logic [STAGES-1:0] cnt_q;
   logic [STAGES:0] ratio_tick;
   logic sel_tick;

   // Counter of fast ticks giving the divided rates
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
      end else if (fast_tick) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign ratio_tick[0] = fast_tick;
   genvar g;
   generate
      for (g = 1; g <= STAGES; g++) begin : g_ratio
         assign ratio_tick[g] = fast_tick && (&cnt_q[g-1:0]);
      end
   endgenerate

   // Whole ticks only, so no runt pulse can leave here
   assign sel_tick = (sel == OMCC_SEL_SLOW) ? slow_tick :
      ratio_tick[sel];

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         core_tick <= 1'b0;
      end else begin
         core_tick <= run && sel_tick;
      end
   end

endmodule : omcc_clk_div
`default_nettype wire

// [hw/omcc_ctrl.sv]
// Operating mode and system clock controller
`timescale 1ns/1ps
`default_nettype none
module omcc_ctrl import omcc_pkg::*; #(
   parameter int SETTLE_CYC = OMCC_SETTLE_CYC
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic watchdog_timeout,
   input wire logic watchdog_clear,
   input wire logic fast_rc_tick,
   input wire logic slow_rc_tick,
   output logic fast_rc_oscillator_en,
   output logic slow_rc_oscillator_en,
   output logic core_clock_tick,
   output logic fast_clock_tick,
   output logic slow_clock_tick,
   output logic slow_osc_raw_clock_tick,
   output omcc_mode_t mode
);

   if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
      $error("omcc_ctrl: SETTLE_CYC out of range");
   end

   omcc_bus_t bus;
   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
      rd: reg_rd};

   // Software state
   logic [2:0] sysclk_source_select_q;
   logic [2:0] sel_act_q;
   logic fast_osc_idle_enable_q;
   logic slow_osc_idle_enable_q;
   logic fast_osc_enable_q;
   logic fast_osc_stable_q;
   logic powerdown_flag_q;
   logic watchdog_expired_flag_q;
   logic watchdog_timer_en_q;
   logic [15:0] settle_q;
   omcc_mode_t mode_q;
   omcc_mode_t mode_d;
   omcc_gates_t gates_d;
   omcc_gates_t gates_q;

   // Address decode
   wire wr_ctrl = bus.wr && (bus.addr == OMCC_CTRL_ADDR);
   wire wr_osc = bus.wr && (bus.addr == OMCC_OSC_ADDR);
   wire wr_wdog = bus.wr && (bus.addr == OMCC_WDOG_ADDR);
   wire fast_en_rise = wr_osc && bus.wdata[OMCC_FEN_BIT] &&
      !fast_osc_enable_q;
   wire halted = !(mode_q inside {OMCC_NORMAL, OMCC_SLOW});
   wire halt_go = halt_req && !halted;
   wire act_slow = (sel_act_q == OMCC_SEL_SLOW);

   // Select field and idle bits
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sysclk_source_select_q <= OMCC_SEL_RST;
         fast_osc_idle_enable_q <= 1'b0;
         slow_osc_idle_enable_q <= 1'b0;
      end else if (wr_ctrl) begin
         sysclk_source_select_q <= bus.wdata[OMCC_SEL_LSB +: 3];
         fast_osc_idle_enable_q <= bus.wdata[OMCC_FIDLE_BIT];
         slow_osc_idle_enable_q <= bus.wdata[OMCC_SIDLE_BIT];
      end
   end

   // Requested source takes over only once it is running
   wire fast_ready = fast_osc_enable_q && fast_osc_stable_q;
   wire new_ready = (sysclk_source_select_q == OMCC_SEL_SLOW) ? 1'b1 :
      fast_ready;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sel_act_q <= OMCC_SEL_RST;
      end else if (sel_act_q != sysclk_source_select_q && new_ready) begin
         sel_act_q <= sysclk_source_select_q;
      end
   end

   // Fast oscillator enable, stable flag and settle count
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fast_osc_enable_q <= OMCC_FAST_EN_RST;
         fast_osc_stable_q <= 1'b0;
         settle_q <= 16'(SETTLE_CYC);
      end else begin
         if (wr_osc) begin
            fast_osc_enable_q <= bus.wdata[OMCC_FEN_BIT];
         end
         if (fast_en_rise || (wr_osc && !bus.wdata[OMCC_FEN_BIT])) begin
            fast_osc_stable_q <= 1'b0;
            settle_q <= 16'(SETTLE_CYC);
         end else if (fast_osc_enable_q && !fast_osc_stable_q) begin
            if (settle_q <= 16'h0001) begin
               fast_osc_stable_q <= 1'b1;
            end else begin
               settle_q <= settle_q - 16'h0001;
            end
         end
      end
   end

   // Watchdog enable and status flags
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         watchdog_timer_en_q <= OMCC_WDT_EN_RST;
         powerdown_flag_q <= 1'b0;
         watchdog_expired_flag_q <= 1'b0;
      end else begin
         if (wr_wdog) begin
            watchdog_timer_en_q <= bus.wdata[0];
         end
         if (halt_go) begin
            powerdown_flag_q <= 1'b1;
         end else if (watchdog_clear) begin
            powerdown_flag_q <= 1'b0;
         end
         if (watchdog_timeout) begin
            watchdog_expired_flag_q <= 1'b1;
         end else if (halt_go || watchdog_clear) begin
            watchdog_expired_flag_q <= 1'b0;
         end
      end
   end

   // Mode selection on halt and wake
   always_comb begin
      mode_d = mode_q;
      if (halt_go) begin
         unique case ({fast_osc_idle_enable_q, slow_osc_idle_enable_q})
            2'b00: mode_d = OMCC_SLEEP;
            2'b01: mode_d = OMCC_IDLE_SLOW;
            2'b11: mode_d = OMCC_IDLE_BOTH;
            2'b10: mode_d = OMCC_IDLE_FAST;
         endcase
      end else if (halted && wake_req) begin
         mode_d = act_slow ? OMCC_SLOW : OMCC_NORMAL;
      end else if (!halted) begin
         mode_d = act_slow ? OMCC_SLOW : OMCC_NORMAL;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= OMCC_NORMAL;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Clock gates per mode
   always_comb begin
      gates_d = '0;
      unique case (mode_q)
         OMCC_NORMAL: begin
            gates_d = '{core_en: 1'b1, fast_en: fast_ready, slow_en: 1'b1,
               slow_raw_en: 1'b1};
         end
         OMCC_SLOW: begin
            gates_d = '{core_en: 1'b1, fast_en: fast_ready, slow_en: 1'b1,
               slow_raw_en: 1'b1};
         end
         OMCC_SLEEP: begin
            gates_d = '{core_en: 1'b0, fast_en: 1'b0, slow_en: 1'b0,
               slow_raw_en: watchdog_timer_en_q};
         end
         OMCC_IDLE_SLOW: begin
            gates_d = '{core_en: act_slow, fast_en: 1'b0, slow_en: 1'b1,
               slow_raw_en: 1'b1};
         end
         OMCC_IDLE_BOTH: begin
            gates_d = '{core_en: 1'b1, fast_en: fast_ready, slow_en: 1'b1,
               slow_raw_en: 1'b1};
         end
         OMCC_IDLE_FAST: begin
            gates_d = '{core_en: !act_slow, fast_en: fast_ready,
               slow_en: 1'b0, slow_raw_en: 1'b1};
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gates_q <= '0;
      end else begin
         gates_q <= gates_d;
      end
   end

   // Core clock from whole divided or slow ticks
   logic core_tick_w;
   omcc_clk_div #(
      .STAGES(6)
   ) u_div (
      .mclk(mclk),
      .reset_n(reset_n),
      .fast_tick(fast_rc_tick && fast_osc_enable_q),
      .slow_tick(slow_rc_tick),
      .sel(sel_act_q),
      .run(gates_q.core_en),
      .core_tick(core_tick_w)
   );

   // Registered clock outputs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fast_rc_oscillator_en <= 1'b0;
         slow_rc_oscillator_en <= 1'b0;
         core_clock_tick <= 1'b0;
         fast_clock_tick <= 1'b0;
         slow_clock_tick <= 1'b0;
         slow_osc_raw_clock_tick <= 1'b0;
         mode <= OMCC_NORMAL;
      end else begin
         fast_rc_oscillator_en <= fast_osc_enable_q &&
            (gates_d.fast_en || !halted);
         slow_rc_oscillator_en <= gates_d.slow_raw_en;
         core_clock_tick <= core_tick_w;
         fast_clock_tick <= gates_q.fast_en && fast_rc_tick;
         slow_clock_tick <= gates_q.slow_en && slow_rc_tick;
         slow_osc_raw_clock_tick <= gates_q.slow_raw_en && slow_rc_tick;
         mode <= mode_q;
      end
   end

   // Read data, one cycle after the strobe
   logic [7:0] rdata_d;
   always_comb begin
      rdata_d = 8'h00;
      unique case (bus.addr)
         OMCC_CTRL_ADDR: begin
            rdata_d[OMCC_SEL_LSB +: 3] = sysclk_source_select_q;
            rdata_d[OMCC_FIDLE_BIT] = fast_osc_idle_enable_q;
            rdata_d[OMCC_SIDLE_BIT] = slow_osc_idle_enable_q;
         end
         OMCC_OSC_ADDR: begin
            rdata_d[OMCC_FSTB_BIT] = fast_osc_stable_q;
            rdata_d[OMCC_FEN_BIT] = fast_osc_enable_q;
         end
         OMCC_STAT_ADDR: begin
            rdata_d[OMCC_WDEXP_BIT] = watchdog_expired_flag_q;
            rdata_d[OMCC_PWRDN_BIT] = powerdown_flag_q;
         end
         OMCC_WDOG_ADDR: begin
            rdata_d[0] = watchdog_timer_en_q;
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (bus.rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule : omcc_ctrl
`default_nettype wire

// [tb/omcc_ctrl_checker.sv]
// Assertion checker bound to the clock controller
`timescale 1ns/1ps
`default_nettype none
module omcc_ctrl_checker import omcc_pkg::*; (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic halt_req,
   input wire logic fast_rc_oscillator_en,
   input wire logic core_clock_tick,
   input wire logic fast_clock_tick,
   input wire logic slow_clock_tick,
   input wire omcc_mode_t mode
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (reg_rd && reg_addr > 4'h3
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   mode_onehot_a: assert property ($onehot(mode))
      else $error("mode not one-hot");
   halt_entry_a: assert property (
      halt_req && mode inside {OMCC_NORMAL, OMCC_SLOW}
      |-> ##[1:3] !(mode inside {OMCC_NORMAL, OMCC_SLOW}))
      else $error("halt did not stop the core");
   sleep_gates_a: assert property (mode == OMCC_SLEEP [*4]
      |-> !core_clock_tick && !fast_clock_tick && !slow_clock_tick)
      else $error("clock tick in sleep");
   idle_slow_a: assert property (mode == OMCC_IDLE_SLOW [*3]
      |-> !fast_clock_tick) else $error("fast tick in slow idle");
   idle_fast_a: assert property (mode == OMCC_IDLE_FAST [*3]
      |-> !slow_clock_tick) else $error("slow tick in fast idle");
   fast_off_a: assert property (!fast_rc_oscillator_en [*3]
      |-> !fast_clock_tick) else $error("fast tick while disabled");
endmodule : omcc_ctrl_checker
bind omcc_ctrl omcc_ctrl_checker u_chk (.mclk(mclk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .halt_req(halt_req), .fast_rc_oscillator_en(fast_rc_oscillator_en),
   .core_clock_tick(core_clock_tick), .fast_clock_tick(fast_clock_tick),
   .slow_clock_tick(slow_clock_tick), .mode(mode));
`default_nettype wire

// [tb/omcc_osc_model.sv]
// Model of the two RC oscillators ticking only while enabled
`timescale 1ns/1ps
`default_nettype none
module omcc_osc_model #(
   parameter int FAST_DIV = 2,
   parameter int SLOW_DIV = 16
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic fast_en,
   input wire logic slow_en,
   output logic fast_tick,
   output logic slow_tick
);
   int fcnt_q;
   int scnt_q;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fcnt_q <= 0;
         scnt_q <= 0;
      end else begin
         fcnt_q <= (fast_en && fcnt_q < FAST_DIV - 1) ? fcnt_q + 1 : 0;
         scnt_q <= (slow_en && scnt_q < SLOW_DIV - 1) ? scnt_q + 1 : 0;
      end
   end
   assign fast_tick = fast_en && (fcnt_q == FAST_DIV - 1);
   assign slow_tick = slow_en && (scnt_q == SLOW_DIV - 1);
endmodule : omcc_osc_model
`default_nettype wire

// [tb/omcc_ctrl_tb_top.sv]
// Self-checking testbench of the clock controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin \
 err_count++; $display("wrong value %s exp %h got %h", nm, e, s); end end
module omcc_ctrl_tb_top import omcc_pkg::*;;
   logic mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, halt_req = 0;
   logic wake_req = 0, wd_to = 0, wd_clr = 0, ftick, stick, fen, sen;
   logic core, fclk, sclk, raw, ok;
   logic [3:0] reg_addr = 4'h0, a;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
   omcc_mode_t mode;
   int err_count = 0, cmp_count = 0, seed = 32293, nf, ns, nc, nr, i, k;
   initial forever #2.5 mclk = ~mclk;
   omcc_ctrl #(.SETTLE_CYC(4)) dut (.mclk(mclk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_req(halt_req),
      .wake_req(wake_req), .watchdog_timeout(wd_to),
      .watchdog_clear(wd_clr), .fast_rc_tick(ftick), .slow_rc_tick(stick),
      .fast_rc_oscillator_en(fen), .slow_rc_oscillator_en(sen),
      .core_clock_tick(core), .fast_clock_tick(fclk),
      .slow_clock_tick(sclk), .slow_osc_raw_clock_tick(raw), .mode(mode));
   omcc_osc_model osc (.mclk(mclk), .reset_n(reset_n), .fast_en(fen),
      .slow_en(sen), .fast_tick(ftick), .slow_tick(stick));
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= dt;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [3:0] ad, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 `CHK("read data", e, reg_rdata)
   endtask : rdchk
   task automatic pulse(input int w);
      @(posedge mclk);
      case (w)
         0: wd_clr <= 1'b1;
         1: wd_to <= 1'b1;
         2: halt_req <= 1'b1;
         default: wake_req <= 1'b1;
      endcase
      @(posedge mclk);
      {wd_clr, wd_to, halt_req, wake_req} <= 4'h0;
   endtask : pulse
   task automatic count(input int n);
      {nf, ns, nc, nr} = '0;
      repeat (n) begin
         @(posedge mclk);
         #1 {nf, ns, nc, nr} = {nf + fclk, ns + sclk, nc + core, nr + raw};
      end
   endtask : count
   task automatic wait_mode(input omcc_mode_t m);
      for (int j = 0; j < 200 && mode !== m; j++) @(posedge mclk);
      #1 `CHK("mode", m, mode)
   endtask : wait_mode
   function automatic omcc_mode_t idle_mode(input logic [1:0] b);
      case (b)
         2'b00: return OMCC_SLEEP;
         2'b01: return OMCC_IDLE_SLOW;
         2'b11: return OMCC_IDLE_BOTH;
         default: return OMCC_IDLE_FAST;
      endcase
   endfunction : idle_mode
   initial begin
      #400000 err_count++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (10) @(posedge mclk);
      #1 `CHK("mode", OMCC_NORMAL, mode)
      rdchk(4'h0, 8'h00);
      rdchk(4'h1, 8'h03);
      rdchk(4'h2, 8'h00);
      rdchk(4'h3, 8'h01);
      for (i = 0; i < 3; i++) begin
         a = 4'h4 + 4'($unsigned($random(seed)) % 12);
         wr(a, 8'($random(seed)));
         rdchk(a, 8'h00);
         rdchk(4'h0, 8'h00);
      end
      wr(4'h1, 8'h00);
      rdchk(4'h1, 8'h00);
      wr(4'h1, 8'h01);
      rdchk(4'h1, 8'h01);
      repeat (10) @(posedge mclk);
      rdchk(4'h1, 8'h03);
      for (k = 0; k < 7; k++) begin
         wr(4'h0, 8'(k << 5));
         repeat (100) @(posedge mclk);
         count(512);
         ok = (nc * (1 << k) - nf) <= (1 << k) &&
            (nf - nc * (1 << k)) <= (1 << k);
         `CHK("divide ratio", 1'b1, ok)
      end
      wr(4'h0, 8'he0);
      wait_mode(OMCC_SLOW);
      repeat (50) @(posedge mclk);
      count(512);
      `CHK("slow core", 1'b1, nc - ns <= 1 && ns - nc <= 1 && ns > 8)
      `CHK("fast kept", 1'b1, nf > 0)
      wr(4'h1, 8'h00);
      repeat (4) @(posedge mclk);
      count(200);
      `CHK("fast stopped", 1'b1, nf == 0 && fen === 1'b0)
      wr(4'h1, 8'h01);
      repeat (20) @(posedge mclk);
      wr(4'h0, 8'h00);
      wait_mode(OMCC_NORMAL);
      for (i = 0; i < 5; i++) begin
         wr(4'h0, {6'h00, 2'(i)});
         if (i == 4) wr(4'h3, 8'h00);
         pulse(0);
         pulse(1);
         pulse(2);
         wait_mode(idle_mode(2'(i)));
         count(200);
         `CHK("fast", i[1], nf != 0)
         `CHK("slow", i[0], ns != 0)
         `CHK("core", i == 2 || i == 3, nc != 0)
         if (i[1:0] == 2'b00) `CHK("raw", i == 0, nr != 0)
         rdchk(4'h2, 8'h10);
         pulse(3);
         wait_mode(OMCC_NORMAL);
      end
      wr(4'h3, 8'h01);
      summarize();
   end
endmodule : omcc_ctrl_tb_top
`default_nettype wire
